// ### bench/ios_exec_monitor.sv
// concurrent checks on the execution unit ports
`timescale 1ns/1ns
module ios_exec_monitor (
    input wire logic                clk_i,
    input wire logic                nrst_i,
    input wire logic                issue_valid_i,
    input wire ios_pkg::ios_op_type op_i,
    input wire logic                dest_i,
    input wire logic [7:0]          reg_data_i,
    input wire logic [7:0]          imm_i,
    input wire logic [3:0]          sfr_addr_i,
    input wire logic [7:0]          sfr_data_i,
    input wire logic [10:0]         pc_i,
    input wire logic                busy_o,
    input wire logic                done_o,
    input wire logic                illegal_o,
    input wire logic [7:0]          acc_o,
    input wire logic                zero_o,
    input wire logic                reg_wr_en_o,
    input wire logic [7:0]          reg_wr_data_o,
    input wire logic                squash_o,
    input wire logic                push_o,
    input wire logic [10:0]         push_data_o,
    input wire logic                pc_load_o,
    input wire logic [10:0]         pc_load_addr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // an issue only counts while the unit is idle
    logic tk;
    assign tk = issue_valid_i && !busy_o;

    a_single_done: assert property (
        tk && op_i inside {3'h0, 3'h2, 3'h3, 3'h4}
        |=> done_o && !busy_o && !squash_o) else $error("single op late");
    a_reg_increment_op_wrap: assert property (
        tk && op_i == 3'h0 && !dest_i |=> acc_o == 8'($past(reg_data_i)
        + 8'h01) && zero_o == (acc_o == 8'h00)) else $error("reg_increment_op bad");
    a_skip_squash: assert property (
        tk && op_i == 3'h1 && reg_data_i == 8'hff |=> squash_o && busy_o
        && !done_o ##1 done_o && !busy_o && !squash_o)
        else $error("skip sequence bad");
    a_noskip_one: assert property (
        tk && op_i == 3'h1 && reg_data_i != 8'hff
        |=> done_o && !squash_o && !busy_o) else $error("no-skip bad");
    a_skip_flags: assert property (
        tk && op_i == 3'h1 |=> $stable(zero_o))
        else $error("skip touched zero");
    a_or_reg_write: assert property (
        tk && op_i == 3'h2 && dest_i |=> reg_wr_en_o && $stable(acc_o)
        && reg_wr_data_o == ($past(acc_o) | $past(reg_data_i)))
        else $error("or reg write bad");
    a_or_imm_acc: assert property (
        tk && op_i == 3'h3 |=> acc_o == ($past(acc_o) | $past(imm_i))
        && zero_o == (acc_o == 8'h00)) else $error("or imm bad");
    a_aux_read: assert property (
        tk && op_i == 3'h4 && sfr_addr_i >= 4'h5 |=> !reg_wr_en_o
        && acc_o == $past(sfr_data_i) && $stable(zero_o))
        else $error("aux read bad");
    a_int_seq: assert property (
        tk && op_i == 3'h5 |=> push_o && !pc_load_o
        && push_data_o == 11'($past(pc_i) + 11'h001)
        ##1 pc_load_o && !push_o && pc_load_addr_o == 11'h001 && busy_o
        ##1 done_o && !busy_o) else $error("soft int sequence bad");

    c_skip: cover property (tk && op_i == 3'h1 && reg_data_i == 8'hff);
    c_int: cover property (push_o ##1 pc_load_o);
    c_illegal: cover property (illegal_o);
endmodule : ios_exec_monitor

// ### bench/ios_exec_test.sv
// self-checking bench for the execution unit
`timescale 1ns/1ns
module ios_exec_test;
    logic                clk_i, nrst_i, issue_valid_i, dest_i;
    ios_pkg::ios_op_type op_i;
    logic [6:0]          reg_addr_i, reg_wr_addr_o;
    logic [7:0]          reg_data_i, imm_i, sfr_data_i, acc_o, reg_wr_data_o;
    logic [3:0]          sfr_addr_i;
    logic [10:0]         pc_i, push_data_o, pc_load_addr_o;
    logic                busy_o, done_o, illegal_o, zero_o, reg_wr_en_o;
    logic                squash_o, push_o, pc_load_o;
    logic [7:0]          acc; // bench copy of the accumulator
    logic                zf;  // bench copy of the zero flag
    int                  error_cnt = 0;
    int                  samples_checked = 0;

    ios_exec DUT (.clk_i(clk_i), .nrst_i(nrst_i),
        .issue_valid_i(issue_valid_i), .op_i(op_i), .reg_addr_i(reg_addr_i),
        .dest_i(dest_i), .reg_data_i(reg_data_i), .imm_i(imm_i),
        .sfr_addr_i(sfr_addr_i), .sfr_data_i(sfr_data_i), .pc_i(pc_i),
        .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o),
        .acc_o(acc_o), .zero_o(zero_o), .reg_wr_en_o(reg_wr_en_o),
        .reg_wr_addr_o(reg_wr_addr_o), .reg_wr_data_o(reg_wr_data_o),
        .squash_o(squash_o), .push_o(push_o), .push_data_o(push_data_o),
        .pc_load_o(pc_load_o), .pc_load_addr_o(pc_load_addr_o));

    // 250 MHz core clock
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic chk_val(input string nm, input logic [10:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    task automatic chk_bit(input string nm, input logic e, g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    // result the operation must produce, from pre-issue state
    function automatic logic [7:0] exp_res(input logic [2:0] op,
                                           input logic [7:0] a, rd, im, sd);
        case (op)
            3'h0, 3'h1: return 8'(rd + 8'h01);
            3'h2:       return a | rd;
            3'h3:       return a | im;
            default:    return sd;
        endcase
    endfunction : exp_res

    // valid stays high after single ops so they run back to back
    task automatic run_op(input logic [2:0] op, input logic d,
                          input logic [7:0] rd, im, input logic [3:0] sa);
        logic [7:0]  res;
        logic        sk, wr;
        logic [10:0] pc;
        op_i          = ios_pkg::ios_op_type'(op);
        dest_i        = d;
        reg_data_i    = rd;
        imm_i         = im;
        sfr_addr_i    = sa;
        sfr_data_i    = 8'($urandom);
        reg_addr_i    = 7'($urandom);
        pc            = 11'($urandom);
        pc_i          = pc;
        issue_valid_i = 1'b1;
        res = exp_res(op, acc, rd, im, sfr_data_i);
        sk  = op == 3'h1 && res == 8'h00;
        wr  = d && op <= 3'h2;
        if (op != 3'h5 && !wr && !(op == 3'h4 && sa < 4'h5))
            acc = res;
        if (op == 3'h0 || op == 3'h2 || op == 3'h3)
            zf = res == 8'h00;
        @(posedge clk_i);
        #1;
        chk_bit("wr_en", wr, reg_wr_en_o);
        if (wr)
        begin
            chk_val("wr_addr", 11'(reg_addr_i), 11'(reg_wr_addr_o));
            chk_val("wr_data", 11'(res), 11'(reg_wr_data_o));
        end
        chk_val("acc", acc, acc_o);
        chk_bit("zero", zf, zero_o);
        chk_bit("squash", sk, squash_o);
        chk_bit("illegal", op == 3'h4 && sa < 4'h5, illegal_o);
        chk_bit("push", op == 3'h5, push_o);
        chk_bit("busy", sk || op == 3'h5, busy_o);
        chk_bit("done", !sk && op != 3'h5, done_o);
        if (sk || op == 3'h5)
        begin
            // an issue while busy must be ignored
            op_i  = ios_pkg::or_acc_imm_op;
            imm_i = 8'hff;
            if (op == 3'h5)
            begin
                chk_val("ret", 11'(pc + 11'h001), push_data_o);
                @(posedge clk_i);
                #1;
                chk_bit("pc_load", 1'b1, pc_load_o);
                chk_val("vector", 11'h001, pc_load_addr_o);
            end
            @(posedge clk_i);
            #1;
            issue_valid_i = 1'b0;
            chk_bit("done_late", 1'b1, done_o);
            chk_val("acc_kept", acc, acc_o);
            @(posedge clk_i);
            #1;
        end
    endtask : run_op

    task automatic do_reset;
        issue_valid_i = 1'b0;
        nrst_i        = 1'b0;
        repeat (12) @(posedge clk_i);
        #1;
        nrst_i = 1'b1;
        acc    = ios_pkg::ACC_RST;
        zf     = ios_pkg::ZERO_RST;
        chk_val("acc_rst", acc, acc_o);
        chk_bit("zero_rst", zf, zero_o);
    endtask : do_reset

    // hang guard well past the expected run length
    initial
    begin
        #200000;
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(32'h17c6));
        do_reset();
        run_op(3'h0, 1'b1, 8'hff, 8'h00, 4'h5);
        run_op(3'h0, 1'b0, 8'h7f, 8'h00, 4'h5);
        run_op(3'h1, 1'b0, 8'hff, 8'h00, 4'h5);
        run_op(3'h1, 1'b1, 8'hff, 8'h00, 4'h5);
        run_op(3'h1, 1'b0, 8'h10, 8'h00, 4'h5);
        run_op(3'h2, 1'b1, 8'h50, 8'h00, 4'h5);
        run_op(3'h4, 1'b0, 8'h00, 8'h00, 4'h4);
        run_op(3'h4, 1'b1, 8'h00, 8'h00, 4'hf);
        run_op(3'h5, 1'b0, 8'h00, 8'h00, 4'h5);
        $display("test corner done");
        // reset mid-run, then an or that leaves zero
        do_reset();
        run_op(3'h3, 1'b0, 8'h00, 8'h00, 4'h5);
        run_op(3'h2, 1'b0, 8'h00, 8'h00, 4'h5);
        $display("test reset done");
        for (int i = 0; i < 300; i++)
            run_op(3'($urandom_range(5, 0)), 1'($urandom),
                   ($urandom_range(3, 0) == 0) ? 8'hff : 8'($urandom),
                   8'($urandom), 4'($urandom));
        $display("test random done");
        wrap_up();
    end
endmodule : ios_exec_test

bind ios_exec ios_exec_monitor mon (.clk_i(clk_i), .nrst_i(nrst_i),
    .issue_valid_i(issue_valid_i), .op_i(op_i), .dest_i(dest_i),
    .reg_data_i(reg_data_i), .imm_i(imm_i), .sfr_addr_i(sfr_addr_i),
    .sfr_data_i(sfr_data_i), .pc_i(pc_i), .busy_o(busy_o),
    .done_o(done_o), .illegal_o(illegal_o), .acc_o(acc_o),
    .zero_o(zero_o), .reg_wr_en_o(reg_wr_en_o),
    .reg_wr_data_o(reg_wr_data_o), .squash_o(squash_o), .push_o(push_o),
    .push_data_o(push_data_o), .pc_load_o(pc_load_o),
    .pc_load_addr_o(pc_load_addr_o));

// ### hdl/ios_alu.sv
// combinational datapath: result, zero test and write steering per operation
`timescale 1ns/1ns
module ios_alu (
    ios_alu_if.alu bus
);

    // true when the aux-page select lies inside the readable window
    function automatic logic sfr_in_range(
        input logic [ios_pkg::SFR_ADDR_W-1:0] a
    );
        sfr_in_range = (a >= ios_pkg::SFR_ADDR_MIN) &&
                       (a <= ios_pkg::SFR_ADDR_MAX);
    endfunction : sfr_in_range

    // result and steering; increment wraps 0xff to 0x00 with no carry out
    always_comb
    begin
        bus.result   = bus.accumulator;
        bus.wr_acc   = 1'b0;
        bus.wr_reg   = 1'b0;
        bus.upd_zero = 1'b0;
        bus.legal    = 1'b1;
        case (bus.op)
            ios_pkg::reg_increment_op:
            begin
                bus.result   = 8'(bus.operand + 8'h01);
                bus.wr_acc   = (bus.dest == ios_pkg::DEST_ACC);
                bus.wr_reg   = (bus.dest == ios_pkg::DEST_REG);
                bus.upd_zero = 1'b1;
            end
            ios_pkg::increment_skip_zero_op:
            begin
                bus.result   = 8'(bus.operand + 8'h01);
                bus.wr_acc   = (bus.dest == ios_pkg::DEST_ACC);
                bus.wr_reg   = (bus.dest == ios_pkg::DEST_REG);
            end
            ios_pkg::or_acc_reg_op:
            begin
                bus.result   = bus.accumulator | bus.operand;
                bus.wr_acc   = (bus.dest == ios_pkg::DEST_ACC);
                bus.wr_reg   = (bus.dest == ios_pkg::DEST_REG);
                bus.upd_zero = 1'b1;
            end
            ios_pkg::or_acc_imm_op:
            begin
                bus.result   = bus.accumulator | bus.imm;
                bus.wr_acc   = 1'b1;
                bus.upd_zero = 1'b1;
            end
            ios_pkg::aux_page_read_op:
            begin
                bus.result   = bus.operand;
                bus.legal    = sfr_in_range(bus.sfr_addr);
                bus.wr_acc   = bus.legal;
            end
            ios_pkg::soft_int_op:
            begin
                bus.result   = bus.accumulator;
            end
            default:
            begin
                bus.legal    = 1'b0;
            end
        endcase
    end

    // zero test on the 8-bit result and the skip decision
    assign bus.result_zero = (bus.result == 8'h00);
    assign bus.skip = (bus.op == ios_pkg::increment_skip_zero_op) &&
                      bus.result_zero;

endmodule : ios_alu

// ### hdl/ios_alu_if.sv
// operand and result bundle between the executer and its datapath
`timescale 1ns/1ns
interface ios_alu_if;
    ios_pkg::ios_op_type                  op;
    logic [ios_pkg::DATA_W-1:0]           accumulator;
    logic [ios_pkg::DATA_W-1:0]           operand;
    logic [ios_pkg::DATA_W-1:0]           imm;
    logic [ios_pkg::SFR_ADDR_W-1:0]       sfr_addr;
    logic                                 dest;
    logic [ios_pkg::DATA_W-1:0]           result;
    logic                                 result_zero;
    logic                                 wr_acc;
    logic                                 wr_reg;
    logic                                 upd_zero;
    logic                                 skip;
    logic                                 legal;

    modport exec (
        output op, accumulator, operand, imm, sfr_addr, dest,
        input  result, result_zero, wr_acc, wr_reg, upd_zero, skip, legal
    );
    modport alu (
        input  op, accumulator, operand, imm, sfr_addr, dest,
        output result, result_zero, wr_acc, wr_reg, upd_zero, skip, legal
    );
endinterface : ios_alu_if

// ### hdl/ios_exec.sv
// execution unit for increment, or, aux-page read and software interrupt
//
// Contract
// - increment register, result to acc or register
// - soft interrupt pushes return, vectors 0x001, 3 cycles
// - increment-skip writes per destination, flags kept
// - zero increment-skip result squashes fetched next instruction
// - increment-skip one cycle, two when skipping
// - or with register, per destination, sets zero
// - or with immediate into acc, sets zero
// - aux-page register copied to acc, flags kept
`timescale 1ns/1ns
module ios_exec (
    input  wire logic                               clk_i,
    input  wire logic                               nrst_i,
    input  wire logic                               issue_valid_i,
    input  wire ios_pkg::ios_op_type                op_i,
    input  wire logic [ios_pkg::REG_ADDR_W-1:0]     reg_addr_i,
    input  wire logic                               dest_i,
    input  wire logic [ios_pkg::DATA_W-1:0]         reg_data_i,
    input  wire logic [ios_pkg::DATA_W-1:0]         imm_i,
    input  wire logic [ios_pkg::SFR_ADDR_W-1:0]     sfr_addr_i,
    input  wire logic [ios_pkg::DATA_W-1:0]         sfr_data_i,
    input  wire logic [ios_pkg::PC_W-1:0]           pc_i,
    output logic                                    busy_o,
    output logic                                    done_o,
    output logic                                    illegal_o,
    output logic [ios_pkg::DATA_W-1:0]              acc_o,
    output logic                                    zero_o,
    output logic                                    reg_wr_en_o,
    output logic [ios_pkg::REG_ADDR_W-1:0]          reg_wr_addr_o,
    output logic [ios_pkg::DATA_W-1:0]              reg_wr_data_o,
    output logic                                    squash_o,
    output logic                                    push_o,
    output logic [ios_pkg::PC_W-1:0]                push_data_o,
    output logic                                    pc_load_o,
    output logic [ios_pkg::PC_W-1:0]                pc_load_addr_o
);

    // one-hot sequencer states; idle accepts a new instruction
    typedef enum logic [3:0] {
        ST_IDLE     = 4'h1,
        ST_SKIP_NOP = 4'h2,
        ST_INT_VEC  = 4'h4,
        ST_INT_TAIL = 4'h8
    } ios_state_type;

    ios_state_type                  state;
    ios_state_type                  next_state;
    logic                           take;
    logic                           is_int;
    logic [ios_pkg::PC_W-1:0]       ret_addr;
    ios_alu_if                      alu_bus ();

    // an instruction is taken only while the sequencer is idle
    assign take   = issue_valid_i && (state == ST_IDLE);
    assign is_int = (op_i == ios_pkg::soft_int_op);

    // return address is the instruction after this one
    assign ret_addr = 11'(pc_i + 11'h001);

    // feed the datapath; aux reads reuse the operand lane
    assign alu_bus.op          = op_i;
    assign alu_bus.accumulator = acc_o;
    assign alu_bus.operand     = (op_i == ios_pkg::aux_page_read_op) ?
                                 sfr_data_i : reg_data_i;
    assign alu_bus.imm         = imm_i;
    assign alu_bus.sfr_addr    = sfr_addr_i;
    assign alu_bus.dest        = dest_i;

    ios_alu u_alu (
        .bus (alu_bus.alu)
    );

    // next state of the multi-cycle sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (take && is_int)
                begin
                    next_state = ST_INT_VEC;
                end
                else if (take && alu_bus.skip)
                begin
                    next_state = ST_SKIP_NOP;
                end
            end
            ST_SKIP_NOP:
            begin
                next_state = ST_IDLE;
            end
            ST_INT_VEC:
            begin
                next_state = ST_INT_TAIL;
            end
            ST_INT_TAIL:
            begin
                next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // sequencer register
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // busy tells decode to hold its next instruction back
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            busy_o <= 1'b0;
        end
        else
        begin
            busy_o <= (next_state != ST_IDLE);
        end
    end

    // completion pulse: single-cycle ops at once, others on the last cycle
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= (take && !is_int && !alu_bus.skip) ||
                      (state == ST_SKIP_NOP) ||
                      (state == ST_INT_TAIL);
        end
    end

    // illegal aux-page select is reported and otherwise ignored
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            illegal_o <= 1'b0;
        end
        else
        begin
            illegal_o <= take && !alu_bus.legal;
        end
    end

    // accumulator; the unit owns it so or-ops see the latest value
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            acc_o <= ios_pkg::ACC_RST;
        end
        else if (take && alu_bus.wr_acc)
        begin
            acc_o <= alu_bus.result;
        end
    end

    // zero flag; skip and aux reads leave it alone
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            zero_o <= ios_pkg::ZERO_RST;
        end
        else if (take && alu_bus.upd_zero)
        begin
            zero_o <= alu_bus.result_zero;
        end
    end

    // register write-back, one-cycle pulse with address and data
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            reg_wr_en_o   <= 1'b0;
            reg_wr_addr_o <= 7'h00;
            reg_wr_data_o <= 8'h00;
        end
        else
        begin
            reg_wr_en_o <= take && alu_bus.wr_reg;
            if (take && alu_bus.wr_reg)
            begin
                reg_wr_addr_o <= reg_addr_i;
                reg_wr_data_o <= alu_bus.result;
            end
        end
    end

    // squash the already fetched next instruction on a zero skip
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            squash_o <= 1'b0;
        end
        else
        begin
            squash_o <= take && alu_bus.skip;
        end
    end

    // stack push comes first, a cycle ahead of the vector load
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            push_o      <= 1'b0;
            push_data_o <= 11'h000;
        end
        else
        begin
            push_o <= take && is_int;
            if (take && is_int)
            begin
                push_data_o <= ret_addr;
            end
        end
    end

    // vector load in the second interrupt cycle; the third drains fetch
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pc_load_o      <= 1'b0;
            pc_load_addr_o <= 11'h000;
        end
        else
        begin
            pc_load_o <= (state == ST_INT_VEC);
            if (state == ST_INT_VEC)
            begin
                pc_load_addr_o <= ios_pkg::INT_VECTOR;
            end
        end
    end

endmodule : ios_exec

// ### hdl/ios_pkg.sv
// shared constants and types for the increment / or / aux-page execution unit
package ios_pkg;

    localparam int unsigned DATA_W     = 8;
    localparam int unsigned REG_ADDR_W = 7;
    localparam int unsigned SFR_ADDR_W = 4;
    localparam int unsigned PC_W       = 11;

    // lowest and highest selectable aux-page special register
    localparam logic [SFR_ADDR_W-1:0] SFR_ADDR_MIN = 4'h5;
    localparam logic [SFR_ADDR_W-1:0] SFR_ADDR_MAX = 4'hf;

    // software interrupt vector loaded into the program counter
    localparam logic [PC_W-1:0] INT_VECTOR = 11'h001;

    // reset values of the state held by this unit
    localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
    localparam logic              ZERO_RST = 1'b0;

    // destination bit encoding
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_REG = 1'b1;

    // cycle counts of the multi-cycle instructions
    localparam int unsigned SKIP_CYCLES = 2;
    localparam int unsigned INT_CYCLES  = 3;

    // operation codes presented by decode
    typedef enum logic [2:0] {
        reg_increment_op       = 3'h0,
        increment_skip_zero_op = 3'h1,
        or_acc_reg_op          = 3'h2,
        or_acc_imm_op          = 3'h3,
        aux_page_read_op       = 3'h4,
        soft_int_op            = 3'h5
    } ios_op_type;

endpackage : ios_pkg
